// ===== hdl/rfcrb_pkg.sv
package rfcrb_pkg;

   // ***********************************************************
   // Serial frame layout.
   // ***********************************************************
   localparam int HDR_BITS = 16;
   localparam int DATA_BITS = 32;
   localparam logic [3:0] MODE_READ = 4'h8;

   // ***********************************************************
   // Register indices, field positions and values after reset.
   // ***********************************************************
   localparam logic [11:0] RF_IF_CONFIGURATION_IDX = 12'h000;
   localparam logic [11:0] TEST_CONTROL_SECOND_IDX = 12'h009;
   localparam logic [11:0] SAMPLE_CLOCK_CONFIGURATION_IDX = 12'h00A;
   localparam int READBACK_CALC_POS = 29;
   localparam logic [31:0] RF_IF_CONFIGURATION_RST = 32'hA2241603;
   localparam logic [31:0] TEST_CONTROL_SECOND_RST = 32'h00000000;
   localparam logic [31:0] SAMPLE_CLOCK_CONFIGURATION_RST = 32'h00000000;
   localparam logic [6:0] IF_FILTER_CENTER_RST = 7'h58;

   // RF and IF configuration word, bit 31 first.
   typedef struct packed {
      logic device_power_enable;
      logic idle_select;
      logic [3:0] fixed_high;
      logic [3:0] fixed_low;
      logic [1:0] keep_upper;
      logic [1:0] keep_lower;
      logic mixer_pole_select;
      logic [1:0] low_noise_amp_band_select;
      logic [1:0] mixer_band_select;
      logic [6:0] if_filter_center;
      logic [2:0] if_filter_bandwidth;
      logic filter_order_select;
      logic polyphase_filter_select;
      logic filter_gain_select;
   } rfcrb_rf_cfg_s;

   // Sample clock configuration word, bit 31 first.
   typedef struct packed {
      logic [3:0] spare_high;
      logic [11:0] sample_clock_l_count;
      logic [11:0] sample_clock_m_count;
      logic pre_fractional_divider_select;
      logic clock_output_select;
      logic [1:0] spare_low;
   } rfcrb_clk_cfg_s;

   // Write request handed from the serial port to the register bank.
   typedef struct packed {
      logic wr;
      logic [11:0] addr;
      logic [31:0] data;
   } rfcrb_req_s;

endpackage

// ===== hdl/rfcrb_serial_port.sv
`timescale 1ns/1ps
`default_nettype none
module rfcrb_serial_port (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic spi_cs_n,
   input wire logic spi_sclk,
   input wire logic spi_sdata_in,
   input wire logic [31:0] rd_data,
   output logic [11:0] look_addr,
   output rfcrb_pkg::rfcrb_req_s req_ff,
   output logic sdata_out_ff,
   output logic sdata_oe_ff
);
   import rfcrb_pkg::*;

   // ***********************************************************
   // Frame sequencer.
   // ***********************************************************
   typedef enum logic [3:0] {
      ST_HDR = 4'b0001,
      ST_WR = 4'b0010,
      ST_RD = 4'b0100,
      ST_HOLD = 4'b1000
   } rfcrb_sp_state_e;

   rfcrb_sp_state_e state_ff, nxt_state;
   logic sclk_prev_ff;
   logic sclk_rise;
   logic [5:0] cnt_ff, nxt_cnt;
   logic [15:0] hdr_ff, nxt_hdr;
   logic [31:0] shift_ff, nxt_shift;
   rfcrb_req_s nxt_req;
   logic nxt_sdata_out, nxt_sdata_oe;

   // The last header bit is still on the pin, so the address is ready.
   assign look_addr = hdr_ff[14:3];
   assign sclk_rise = spi_sclk & ~sclk_prev_ff;

   // Next values: shift on rising clock edges while selected.
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_hdr = hdr_ff;
      nxt_shift = shift_ff;
      nxt_req = req_ff;
      nxt_req.wr = 1'b0;
      nxt_sdata_out = sdata_out_ff;
      nxt_sdata_oe = sdata_oe_ff;
      if (spi_cs_n) begin
         nxt_state = ST_HDR;
         nxt_cnt = 6'h00;
         nxt_sdata_oe = 1'b0;
      end else if (sclk_rise) begin
         nxt_cnt = cnt_ff + 6'h01;
         unique case (state_ff)
            ST_HDR: begin
               nxt_hdr = {hdr_ff[14:0], spi_sdata_in};
               if (cnt_ff == 6'(HDR_BITS - 1)) begin
                  nxt_cnt = 6'h00;
                  nxt_req.addr = look_addr;
                  if (nxt_hdr[3:0] == MODE_READ) begin
                     nxt_state = ST_RD;
                     nxt_sdata_out = rd_data[31];
                     nxt_sdata_oe = 1'b1;
                     nxt_shift = {rd_data[30:0], 1'b0};
                  end else begin
                     nxt_state = ST_WR;
                  end
               end
            end
            ST_WR: begin
               nxt_shift = {shift_ff[30:0], spi_sdata_in};
               if (cnt_ff == 6'(DATA_BITS - 1)) begin
                  nxt_req.wr = 1'b1;
                  nxt_req.data = nxt_shift;
                  nxt_state = ST_HOLD;
               end
            end
            ST_RD: begin
               if (cnt_ff == 6'(DATA_BITS - 1)) begin
                  nxt_sdata_oe = 1'b0;
                  nxt_state = ST_HOLD;
               end else begin
                  nxt_sdata_out = shift_ff[31];
                  nxt_shift = {shift_ff[30:0], 1'b0};
               end
            end
            ST_HOLD: begin
               nxt_cnt = cnt_ff;
            end
         endcase
      end
   end

   // State registers.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= ST_HDR;
         sclk_prev_ff <= 1'b0;
         cnt_ff <= 6'h00;
         hdr_ff <= 16'h0000;
         shift_ff <= 32'h00000000;
         req_ff <= '0;
         sdata_out_ff <= 1'b0;
         sdata_oe_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         sclk_prev_ff <= spi_sclk;
         cnt_ff <= nxt_cnt;
         hdr_ff <= nxt_hdr;
         shift_ff <= nxt_shift;
         req_ff <= nxt_req;
         sdata_out_ff <= nxt_sdata_out;
         sdata_oe_ff <= nxt_sdata_oe;
      end
   end

endmodule
`default_nettype wire

// ===== hdl/rfcrb_register_bank.sv
`timescale 1ns/1ps
`default_nettype none
module rfcrb_register_bank (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic spi_cs_n,
   input wire logic spi_sclk,
   input wire logic spi_sdata_in,
   output logic spi_sdata_out,
   output logic spi_sdata_oe,
   output rfcrb_pkg::rfcrb_rf_cfg_s rf_cfg_ff,
   output logic [31:0] test_ctrl_ff,
   output rfcrb_pkg::rfcrb_clk_cfg_s clk_cfg_ff,
   output logic receiver_active_ff,
   output logic readback_calculation_bit_ff
);
   import rfcrb_pkg::*;

   // ***********************************************************
   // Reset release.
   // ***********************************************************
   logic rst_meta_ff;
   logic rst_n;

   // Assertion is immediate, release passes two flip-flops.
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta_ff <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n <= rst_meta_ff;
      end
   end

   // ***********************************************************
   // Address decode.
   // ***********************************************************

   // Returns a one-hot select: bit 0 RF/IF, bit 1 test, bit 2 clock.
   function automatic logic [2:0] reg_select(input logic [11:0] addr);
      logic [2:0] sel;
      sel = 3'h0;
      if (addr == RF_IF_CONFIGURATION_IDX) begin
         sel[0] = 1'b1;
      end
      if (addr == TEST_CONTROL_SECOND_IDX) begin
         sel[1] = 1'b1;
      end
      if (addr == SAMPLE_CLOCK_CONFIGURATION_IDX) begin
         sel[2] = 1'b1;
      end
      return sel;
   endfunction

   // ***********************************************************
   // Serial port.
   // ***********************************************************
   logic [11:0] look_addr;
   logic [2:0] look_sel;
   logic [31:0] rd_data;
   rfcrb_req_s req_ff;
   logic [2:0] wr_sel;

   // The port runs from the same reset regardless of power state.
   rfcrb_serial_port u_port (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .spi_cs_n(spi_cs_n),
      .spi_sclk(spi_sclk),
      .spi_sdata_in(spi_sdata_in),
      .rd_data(rd_data),
      .look_addr(look_addr),
      .req_ff(req_ff),
      .sdata_out_ff(spi_sdata_out),
      .sdata_oe_ff(spi_sdata_oe)
   );

   // Read mux; unmapped addresses read as zero.
   always_comb begin
      look_sel = reg_select(look_addr);
      rd_data = 32'h00000000;
      if (look_sel[0]) begin
         rd_data = rf_cfg_ff;
      end else if (look_sel[1]) begin
         rd_data = test_ctrl_ff;
      end else if (look_sel[2]) begin
         rd_data = clk_cfg_ff;
      end
   end

   // ***********************************************************
   // Register bank.
   // ***********************************************************
   rfcrb_rf_cfg_s nxt_rf_cfg;
   rfcrb_clk_cfg_s nxt_clk_cfg;
   logic [31:0] nxt_test_ctrl;
   logic nxt_active, nxt_readback;

   // Whole-word writes; reserved fields store what the host sends.
   always_comb begin
      wr_sel = reg_select(req_ff.addr);
      nxt_rf_cfg = rf_cfg_ff;
      nxt_test_ctrl = test_ctrl_ff;
      nxt_clk_cfg = clk_cfg_ff;
      if (req_ff.wr && wr_sel[0]) begin
         nxt_rf_cfg = rfcrb_rf_cfg_s'(req_ff.data);
      end
      if (req_ff.wr && wr_sel[1]) begin
         nxt_test_ctrl = req_ff.data;
      end
      if (req_ff.wr && wr_sel[2]) begin
         nxt_clk_cfg = rfcrb_clk_cfg_s'(req_ff.data);
      end
      // Receiver runs only when powered and not idle.
      nxt_active = nxt_rf_cfg.device_power_enable &
                   ~nxt_rf_cfg.idle_select;
      nxt_readback = nxt_test_ctrl[READBACK_CALC_POS];
   end

   // Register update.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rf_cfg_ff <= rfcrb_rf_cfg_s'(RF_IF_CONFIGURATION_RST);
         test_ctrl_ff <= TEST_CONTROL_SECOND_RST;
         clk_cfg_ff <= rfcrb_clk_cfg_s'(SAMPLE_CLOCK_CONFIGURATION_RST);
         receiver_active_ff <= 1'b1;
         readback_calculation_bit_ff <= 1'b0;
      end else begin
         rf_cfg_ff <= nxt_rf_cfg;
         test_ctrl_ff <= nxt_test_ctrl;
         clk_cfg_ff <= nxt_clk_cfg;
         receiver_active_ff <= nxt_active;
         readback_calculation_bit_ff <= nxt_readback;
      end
   end

   // ***********************************************************
   // Checks.
   // ***********************************************************
   power_off_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (req_ff.wr && req_ff.addr == RF_IF_CONFIGURATION_IDX)
      |=> (rf_cfg_ff.device_power_enable == $past(req_ff.data[31]))
          && ($past(req_ff.data[31]) || !receiver_active_ff))
      else $error("Power enable did not follow the written bit.");

   idle_readback_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (req_ff.wr && req_ff.addr == RF_IF_CONFIGURATION_IDX)
      ##1 (look_addr == RF_IF_CONFIGURATION_IDX)
      |-> rd_data[30] == $past(req_ff.data[30]))
      else $error("Idle bit does not read back as written.");

   pole_select_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      ($rose(rst_n) |-> !rf_cfg_ff.mixer_pole_select)
      and ((req_ff.wr && wr_sel[0])
           |=> rf_cfg_ff.mixer_pole_select == $past(req_ff.data[17])))
      else $error("Mixer pole select wrong after reset or write.");

   // The pole select only moves on a write to its word.
   pole_hold_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      !(req_ff.wr && wr_sel[0]) |=> $stable(rf_cfg_ff.mixer_pole_select))
      else $error("Mixer pole select changed without a write.");

   // Idle bit and receiver state follow the written word.
   idle_state_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (req_ff.wr && wr_sel[0])
      |=> rf_cfg_ff.idle_select == $past(req_ff.data[30])
          && receiver_active_ff
             == ($past(req_ff.data[31]) && !$past(req_ff.data[30])))
      else $error("Idle bit or receiver state not as written.");

   // A powered-down device still takes writes over the serial port.
   serial_alive_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (req_ff.wr && wr_sel[0] && !rf_cfg_ff.device_power_enable)
      |=> rf_cfg_ff == $past(req_ff.data))
      else $error("Register write lost while powered down.");

   // Every low field lands at its own place.
   low_fields_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (req_ff.wr && wr_sel[0])
      |=> {rf_cfg_ff.low_noise_amp_band_select, rf_cfg_ff.mixer_band_select,
           rf_cfg_ff.if_filter_center, rf_cfg_ff.if_filter_bandwidth,
           rf_cfg_ff.filter_order_select, rf_cfg_ff.polyphase_filter_select,
           rf_cfg_ff.filter_gain_select} == $past(req_ff.data[16:0]))
      else $error("Low configuration fields not stored.");

   // The clock output select sits just below the divider select.
   clock_out_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (req_ff.wr && wr_sel[2])
      |=> clk_cfg_ff.clock_output_select == $past(req_ff.data[2]))
      else $error("Clock output select not stored.");

   center_reset_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      $rose(rst_n) |-> rf_cfg_ff.if_filter_center == IF_FILTER_CENTER_RST
                       && rf_cfg_ff.low_noise_amp_band_select == 2'h0)
      else $error("Filter centre not at its reset value.");

   clock_fields_a: assert property (
      @(posedge sys_clk) disable iff (!rst_n)
      (req_ff.wr && req_ff.addr == SAMPLE_CLOCK_CONFIGURATION_IDX)
      |=> clk_cfg_ff.sample_clock_l_count == $past(req_ff.data[27:16])
          && clk_cfg_ff.sample_clock_m_count == $past(req_ff.data[15:4])
          && clk_cfg_ff.pre_fractional_divider_select
             == $past(req_ff.data[3]))
      else $error("Clock configuration fields not stored.");

endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import rfcrb_pkg::*;

   // ***********************************************************
   // Stimulus, design and bookkeeping.
   // ***********************************************************
   logic sys_clk;
   logic arst_n;
   logic spi_cs_n;
   logic spi_sclk;
   logic spi_sdata_in;
   logic spi_sdata_out;
   logic spi_sdata_oe;
   rfcrb_rf_cfg_s rf_cfg_ff;
   logic [31:0] test_ctrl_ff;
   rfcrb_clk_cfg_s clk_cfg_ff;
   logic receiver_active_ff;
   logic readback_calculation_bit_ff;
   int err_count;
   int total_checks;
   int cycle_count;
   logic [31:0] rd;
   logic [31:0] w;

   // Clock of 5 ns period.
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   rfcrb_register_bank rfcrb_register_bank_i (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .spi_cs_n(spi_cs_n),
      .spi_sclk(spi_sclk),
      .spi_sdata_in(spi_sdata_in),
      .spi_sdata_out(spi_sdata_out),
      .spi_sdata_oe(spi_sdata_oe),
      .rf_cfg_ff(rf_cfg_ff),
      .test_ctrl_ff(test_ctrl_ff),
      .clk_cfg_ff(clk_cfg_ff),
      .receiver_active_ff(receiver_active_ff),
      .readback_calculation_bit_ff(readback_calculation_bit_ff)
   );

   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Compares one value of up to 32 bits.
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Sends nbits of one frame; fewer than 48 aborts it.
   // Read bits are caught in the low phase, before the next rise.
   task automatic xfer(input logic [11:0] a, input logic [3:0] m,
                       input logic [31:0] wd, input int nbits,
                       output logic [31:0] rdata);
      logic [47:0] frame;
      frame = {a, m, wd};
      rdata = 32'h0;
      @(posedge sys_clk);
      spi_cs_n <= 1'b0;
      for (int i = 0; i < nbits; i++) begin
         @(posedge sys_clk);
         spi_sclk <= 1'b0;
         spi_sdata_in <= (m == MODE_READ && i >= 16) ? i[0] : frame[47 - i];
         repeat (2) @(posedge sys_clk);
         @(negedge sys_clk);
         if (i >= 16) begin
            rdata[47 - i] = spi_sdata_out;
         end
         if (i == 16 && m == MODE_READ) begin
            chk("oe", 32'h1, {31'h0, spi_sdata_oe});
         end
         @(posedge sys_clk);
         spi_sclk <= 1'b1;
         repeat (2) @(posedge sys_clk);
      end
      repeat (2) @(posedge sys_clk);
      spi_sclk <= 1'b0;
      spi_cs_n <= 1'b1;
      repeat (4) @(posedge sys_clk);
   endtask

   // Writes one register with the given mode code.
   task automatic wr(input logic [11:0] a, input logic [3:0] m,
                     input logic [31:0] d);
      logic [31:0] unused;
      xfer(a, m, d, 48, unused);
   endtask

   // Reads one register and checks it and the released data line.
   task automatic rdchk(input string what, input logic [11:0] a,
                        input logic [31:0] exp);
      logic [31:0] got;
      xfer(a, MODE_READ, 32'h0, 48, got);
      chk(what, exp, got);
      chk("oe off", 32'h0, {31'h0, spi_sdata_oe});
   endtask

   // Cuts a hang short.
   always @(posedge sys_clk) begin
      cycle_count <= cycle_count + 1;
      if (cycle_count == 20000) begin
         err_count++;
         tally_and_finish();
      end
   end

   // ***********************************************************
   // Test sequence.
   // ***********************************************************
   initial begin
      arst_n = 1'b0;
      spi_cs_n = 1'b1;
      spi_sclk = 1'b0;
      spi_sdata_in = 1'b0;
      repeat (5) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (6) @(posedge sys_clk);
      chk("rf rst", RF_IF_CONFIGURATION_RST, rf_cfg_ff);
      chk("ctr rst", 32'h58, {25'h0, rf_cfg_ff.if_filter_center});
      chk("pole rst", 32'h0, {31'h0, rf_cfg_ff.mixer_pole_select});
      chk("tst rst", TEST_CONTROL_SECOND_RST, test_ctrl_ff);
      chk("clk rst", SAMPLE_CLOCK_CONFIGURATION_RST, clk_cfg_ff);
      chk("act rst", 32'h1, {31'h0, receiver_active_ff});
      rdchk("rf rd", RF_IF_CONFIGURATION_IDX, RF_IF_CONFIGURATION_RST);
      // Idle set by read-modify-write, keep fields kept as read, fixed fields written as F and A.
      xfer(RF_IF_CONFIGURATION_IDX, MODE_READ, 32'h0, 48, rd);
      w = {rd[31], 1'b1, 4'hF, 4'hA,
           rd[21:18], rd[17:0]};
      wr(RF_IF_CONFIGURATION_IDX, 4'h0, w);
      chk("idle", w, rf_cfg_ff);
      chk("act idle", 32'h0, {31'h0, receiver_active_ff});
      rdchk("idle rd", RF_IF_CONFIGURATION_IDX, w);
      // Power off with every low field given a value other than its reset value.
      w = {2'b00, 4'hF, 4'hA, w[21:18], 1'b1, 2'h2, 2'h1, 7'h35, 3'h7,
           3'b100};
      wr(RF_IF_CONFIGURATION_IDX, 4'h3, w);
      chk("pole", 32'h1, {31'h0, rf_cfg_ff.mixer_pole_select});
      chk("fields", {15'h0, w[16:0]}, {15'h0,
          rf_cfg_ff.low_noise_amp_band_select, rf_cfg_ff.mixer_band_select,
          rf_cfg_ff.if_filter_center, rf_cfg_ff.if_filter_bandwidth,
          rf_cfg_ff.filter_order_select, rf_cfg_ff.polyphase_filter_select,
          rf_cfg_ff.filter_gain_select});
      chk("act off", 32'h0, {31'h0, receiver_active_ff});
      rdchk("off rd", RF_IF_CONFIGURATION_IDX, w);
      w[31] = 1'b1;
      wr(RF_IF_CONFIGURATION_IDX, 4'hF, w);
      chk("act on", 32'h1, {31'h0, receiver_active_ff});
      // Sample clock word fields.
      w = 32'h0ABCDE5C;
      wr(SAMPLE_CLOCK_CONFIGURATION_IDX, 4'h0, w);
      chk("clk", {6'h0, w[27:2]}, {6'h0, clk_cfg_ff.sample_clock_l_count,
          clk_cfg_ff.sample_clock_m_count,
          clk_cfg_ff.pre_fractional_divider_select,
          clk_cfg_ff.clock_output_select});
      rdchk("clk rd", SAMPLE_CLOCK_CONFIGURATION_IDX, w);
      // Test register and its exported bit.
      wr(TEST_CONTROL_SECOND_IDX, 4'h0, 32'h20005A5A);
      chk("tst", 32'h20005A5A, test_ctrl_ff);
      chk("calc", 32'h1, {31'h0, readback_calculation_bit_ff});
      rdchk("tst rd", TEST_CONTROL_SECOND_IDX, 32'h20005A5A);
      // Unmapped place and an aborted frame change nothing.
      wr(12'h005, 4'h0, 32'hFFFFFFFF);
      rdchk("unmap rd", 12'h005, 32'h0);
      xfer(SAMPLE_CLOCK_CONFIGURATION_IDX, 4'h0, 32'h0, 40, rd);
      chk("abort", w, clk_cfg_ff);
      // A second reset in mid-run.
      @(posedge sys_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      arst_n <= 1'b1;
      repeat (6) @(posedge sys_clk);
      chk("rf rst2", RF_IF_CONFIGURATION_RST, rf_cfg_ff);
      chk("act rst2", 32'h1, {31'h0, receiver_active_ff});
      chk("calc rst2", 32'h0, {31'h0, readback_calculation_bit_ff});
      chk("clk rst2", SAMPLE_CLOCK_CONFIGURATION_RST, clk_cfg_ff);
      tally_and_finish();
   end
endmodule
`default_nettype wire
